/* tarf_pkg.sv */
// constants for the type-a rate and framing configuration block
// assumes a 32-bit axi4-lite register bus and a 40 MHz system clock
package tarf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] BIT_RATE_SELECT_IDX   = 8'h04;
	localparam logic [7:0] TYPEA_FRAMING_IDX     = 8'h05;
	localparam logic [7:0] CONFIG_STATUS_IDX     = 8'h06;
	localparam logic [7:0] BIT_RATE_SELECT_RESET = 8'h00;
	localparam logic [7:0] TYPEA_FRAMING_RESET   = 8'h00;
	// writable bits of bit_rate_select; the rest read as zero
	localparam logic [7:0] BIT_RATE_SELECT_MASK  = 8'h33;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int TX_RATE_LSB          = 4;
	localparam int RX_RATE_LSB          = 0;
	localparam int OMIT_TX_PARITY_BIT   = 7;
	localparam int RAW_RX_PARITY_BIT    = 6;
	localparam int TRANSPORT_FRAME_BIT  = 5;
	localparam int PAUSE_CODE_LSB       = 1;
	localparam int COLLISION_FRAME_BIT  = 0;
	localparam int STAT_TX_ENABLE_BIT   = 7;
	localparam int STAT_RX_ENABLE_BIT   = 6;

	////////////////////////////////////////////////////////////////////////////
	// rate codes and carrier divisors
	localparam logic [1:0] RATE_DIV128 = 2'h0;
	localparam logic [1:0] RATE_DIV64  = 2'h1;
	localparam logic [1:0] RATE_DIV32  = 2'h2;
	localparam logic [1:0] RATE_DIV16  = 2'h3;
	localparam logic [7:0] DIVISOR_MAX = 8'h80;

	////////////////////////////////////////////////////////////////////////////
	// pause width bases and signed code limits, per rate
	localparam logic [5:0] PAUSE_BASE_128 = 6'h23;
	localparam logic [5:0] PAUSE_BASE_64  = 6'h12;
	localparam logic [5:0] PAUSE_BASE_32  = 6'h09;
	localparam logic [5:0] PAUSE_BASE_16  = 6'h05;
	localparam logic [3:0] PAUSE_LIM_128  = 4'h8;
	localparam logic [3:0] PAUSE_LIM_64   = 4'h6;
	localparam logic [3:0] PAUSE_LIM_32   = 4'h4;
	localparam logic [3:0] PAUSE_LIM_16   = 4'h3;

	////////////////////////////////////////////////////////////////////////////
	// transport frame and bus answers
	localparam logic [7:0] TRANSPORT_START_BYTE = 8'hf0;
	localparam logic [1:0] RESP_OKAY            = 2'h0;
	localparam logic [1:0] RESP_SLVERR          = 2'h2;

endpackage

/* tarf_rate_divider.sv */
// bit-period tick generator for one direction
// assumes carrier_tick_i is a one-cycle enable from the same clock
`timescale 1ns/1ps
module tarf_rate_divider (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// control
	input  wire logic       enable_i,
	input  wire logic [1:0] rate_i,
	input  wire logic       carrier_tick_i,
	// tick out
	output logic            bit_tick_o
);

	logic [7:0] count_r;
	logic [7:0] count_nxt;
	wire  [7:0] period = tarf_pkg::DIVISOR_MAX >> rate_i;
	wire        wrap   = (count_r >= period - 8'h01);

	assign count_nxt = wrap ? 8'h00 : count_r + 8'h01;

	always_ff @(posedge clk_i) begin
		if (reset_i || !enable_i) begin
			count_r    <= 8'h00;
			bit_tick_o <= 1'b0;
		end else begin
			bit_tick_o <= carrier_tick_i && wrap;
			if (carrier_tick_i) begin
				count_r <= count_nxt;
			end
		end
	end

endmodule

/* tarf_pause_width.sv */
// modulation pause width from rate and signed code
// purely combinational; caller registers the result
`timescale 1ns/1ps
module tarf_pause_width (
	// inputs
	input  wire logic [1:0] rate_i,
	input  wire logic [3:0] code_i,
	// outputs
	output logic [5:0]      width_o,
	output logic            valid_o
);

	logic [5:0] base;
	logic [3:0] lim;
	wire        neg  = code_i[3];
	wire  [3:0] mag  = neg ? (4'h0 - code_i) : code_i;

	always_comb begin
		case (rate_i)
			tarf_pkg::RATE_DIV128: begin
				base = tarf_pkg::PAUSE_BASE_128;
				lim  = tarf_pkg::PAUSE_LIM_128;
			end
			tarf_pkg::RATE_DIV64: begin
				base = tarf_pkg::PAUSE_BASE_64;
				lim  = tarf_pkg::PAUSE_LIM_64;
			end
			tarf_pkg::RATE_DIV32: begin
				base = tarf_pkg::PAUSE_BASE_32;
				lim  = tarf_pkg::PAUSE_LIM_32;
			end
			default: begin
				base = tarf_pkg::PAUSE_BASE_16;
				lim  = tarf_pkg::PAUSE_LIM_16;
			end
		endcase
	end

	// /128 takes every code; other rates allow -lim to +lim
	assign valid_o = neg ? (mag <= lim)
	                     : ((rate_i == tarf_pkg::RATE_DIV128) ? 1'b1 : (mag <= lim));
	assign width_o = neg ? (base - {2'h0, mag}) : (base + {2'h0, mag});

endmodule

/* tarf_config_top.sv */
// type-a rate and framing configuration with axi4-lite registers
// assumes one clock; carrier_tick_i and link byte strobes come from same-clock logic
//
// Notes on behaviour
// [R1] tx rate field picks carrier/128 down to /16
// [R2] rx rate field chosen independently, same coding
// [R3] unsupported setting disables tx and rx; code disables tx alone, on a bad pause code
// [R4] omit-parity bit stops tx parity generation
// [R5] raw parity stores all bits, 106k only
// [R6] software uses parity options in reader modes only
// [R7] transport frame adds F0 and length, drops F0
// [R8] software keeps transport frame off in rate detection
// [R9] collision-frame bit selects anticollision frame reception
// [R10] four-bit pause code sits in bits 4:1
// [R11] pause width is rate base plus signed code
// [R12] reserved bits read zero; bad pause code unsupported
`timescale 1ns/1ps
module tarf_config_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// axi4-lite write
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// carrier timing
	input  wire logic        carrier_tick_i,
	output logic             tx_bit_tick_o,
	output logic             rx_bit_tick_o,
	// framing controls to coder and decoder
	output logic             tx_enable_o,
	output logic             rx_enable_o,
	output logic             tx_parity_gen_o,
	output logic             raw_rx_parity_o,
	output logic             rx_check_o,
	output logic             collision_frame_o,
	output logic [5:0]       pause_width_o,
	// transport frame header on transmit
	input  wire logic        tx_start_i,
	input  wire logic [7:0]  tx_len_i,
	output logic             hdr_valid_o,
	output logic [7:0]       hdr_data_o,
	input  wire logic        hdr_ready_i,
	// receive byte path
	input  wire logic        rx_frame_start_i,
	input  wire logic        rx_byte_valid_i,
	input  wire logic [7:0]  rx_byte_i,
	output logic             rx_out_valid_o,
	output logic [7:0]       rx_out_data_o
);

	////////////////////////////////////////////////////////////////////////////
	// register file

	function automatic logic [7:0] addr_index(input logic [31:0] addr);
		return addr[9:2];
	endfunction

	logic [7:0] bit_rate_r;
	logic [7:0] framing_r;
	logic       bvalid_r;
	logic [1:0] bresp_r;
	logic       rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	wire [7:0] wr_idx   = addr_index(s_axi_awaddr);
	wire [7:0] rd_idx   = addr_index(s_axi_araddr);
	wire       wr_take  = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	wire       rd_take  = s_axi_arvalid && !rvalid_r;
	wire       wr_rate  = wr_take && wr_idx == tarf_pkg::BIT_RATE_SELECT_IDX;
	wire       wr_frame = wr_take && wr_idx == tarf_pkg::TYPEA_FRAMING_IDX;
	wire       wr_ok    = wr_rate || wr_frame || (wr_idx == tarf_pkg::CONFIG_STATUS_IDX);
	wire       rd_ok    = rd_idx == tarf_pkg::BIT_RATE_SELECT_IDX
	                   || rd_idx == tarf_pkg::TYPEA_FRAMING_IDX
	                   || rd_idx == tarf_pkg::CONFIG_STATUS_IDX;

	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = rd_take;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	////////////////////////////////////////////////////////////////////////////
	// decoded fields

	// [R1] tx rate field
	wire [1:0] tx_rate    = bit_rate_r[tarf_pkg::TX_RATE_LSB +: 2];
	// [R2] rx rate field
	wire [1:0] rx_rate    = bit_rate_r[tarf_pkg::RX_RATE_LSB +: 2];
	// [R10] pause code bits
	wire [3:0] pause_code = framing_r[tarf_pkg::PAUSE_CODE_LSB +: 4];
	wire       omit_par   = framing_r[tarf_pkg::OMIT_TX_PARITY_BIT];
	wire       raw_par    = framing_r[tarf_pkg::RAW_RX_PARITY_BIT];
	wire       xport_en   = framing_r[tarf_pkg::TRANSPORT_FRAME_BIT];
	wire [5:0] pause_w;
	wire       pause_ok;
	wire [7:0] status_byte;

	// [R11] base plus signed code
	tarf_pause_width u_pause (
		.rate_i  (tx_rate),
		.code_i  (pause_code),
		.width_o (pause_w),
		.valid_o (pause_ok)
	);

	// [R3] only codes with upper bits zero are supported; field width keeps them zero
	wire rate_ok = ({2'h0, tx_rate} <= {2'h0, tarf_pkg::RATE_DIV16})
	            && ({2'h0, rx_rate} <= {2'h0, tarf_pkg::RATE_DIV16});
	// [R12] out-of-range pause blocks transmit
	wire tx_en_nxt = rate_ok && pause_ok;
	wire rx_en_nxt = rate_ok;

	assign status_byte = {tx_enable_o, rx_enable_o, pause_width_o};

	////////////////////////////////////////////////////////////////////////////
	// bus processes

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bit_rate_r <= tarf_pkg::BIT_RATE_SELECT_RESET;
			framing_r  <= tarf_pkg::TYPEA_FRAMING_RESET;
			bvalid_r   <= 1'b0;
			bresp_r    <= tarf_pkg::RESP_OKAY;
		end else begin
			// [R12] reserved bits never stored
			if (wr_rate && s_axi_wstrb[0]) begin
				bit_rate_r <= s_axi_wdata[7:0] & tarf_pkg::BIT_RATE_SELECT_MASK;
			end
			if (wr_frame && s_axi_wstrb[0]) begin
				framing_r <= s_axi_wdata[7:0];
			end
			if (wr_take) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok ? tarf_pkg::RESP_OKAY : tarf_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	wire [7:0] rd_byte = (rd_idx == tarf_pkg::BIT_RATE_SELECT_IDX) ? bit_rate_r :
	                     (rd_idx == tarf_pkg::TYPEA_FRAMING_IDX)   ? framing_r  :
	                     (rd_idx == tarf_pkg::CONFIG_STATUS_IDX)   ? status_byte : 8'h00;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= tarf_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= {24'h00_0000, rd_byte};
			rresp_r  <= rd_ok ? tarf_pkg::RESP_OKAY : tarf_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registered controls

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_enable_o       <= 1'b0;
			rx_enable_o       <= 1'b0;
			tx_parity_gen_o   <= 1'b1;
			raw_rx_parity_o   <= 1'b0;
			rx_check_o        <= 1'b1;
			collision_frame_o <= 1'b0;
			pause_width_o     <= tarf_pkg::PAUSE_BASE_128;
		end else begin
			tx_enable_o       <= tx_en_nxt;
			rx_enable_o       <= rx_en_nxt;
			// [R4] no parity on transmit
			tx_parity_gen_o   <= !omit_par;
			// [R5] raw stream only at 106k
			raw_rx_parity_o   <= raw_par && rx_rate == tarf_pkg::RATE_DIV128;
			rx_check_o        <= !(raw_par && rx_rate == tarf_pkg::RATE_DIV128);
			// [R9] anticollision frame reception
			collision_frame_o <= framing_r[tarf_pkg::COLLISION_FRAME_BIT];
			pause_width_o     <= pause_w;
		end
	end

	// [R1] tx bit period
	tarf_rate_divider u_tx_div (
		.clk_i          (clk_i),
		.reset_i        (reset_i),
		.enable_i       (tx_enable_o),
		.rate_i         (tx_rate),
		.carrier_tick_i (carrier_tick_i),
		.bit_tick_o     (tx_bit_tick_o)
	);

	// [R2] rx bit period
	tarf_rate_divider u_rx_div (
		.clk_i          (clk_i),
		.reset_i        (reset_i),
		.enable_i       (rx_enable_o),
		.rate_i         (rx_rate),
		.carrier_tick_i (carrier_tick_i),
		.bit_tick_o     (rx_bit_tick_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// transport frame header and start byte removal

	typedef enum logic [1:0] {HDR_IDLE, HDR_START, HDR_LEN} tarf_hdr_state_type;
	tarf_hdr_state_type hdr_r;
	logic [7:0] len_r;
	logic       rx_first_r;

	assign hdr_valid_o = (hdr_r != HDR_IDLE);

	// [R7] start byte then length
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hdr_r      <= HDR_IDLE;
			len_r      <= 8'h00;
			hdr_data_o <= 8'h00;
		end else begin
			case (hdr_r)
				HDR_IDLE: begin
					if (tx_start_i && xport_en && tx_enable_o) begin
						hdr_r      <= HDR_START;
						len_r      <= tx_len_i;
						hdr_data_o <= tarf_pkg::TRANSPORT_START_BYTE;
					end
				end
				HDR_START: begin
					if (hdr_ready_i) begin
						hdr_r      <= HDR_LEN;
						hdr_data_o <= len_r;
					end
				end
				HDR_LEN: begin
					if (hdr_ready_i) begin
						hdr_r <= HDR_IDLE;
					end
				end
				default: begin
					hdr_r <= HDR_IDLE;
				end
			endcase
		end
	end

	// [R7] leading start byte dropped
	wire rx_drop = xport_en && rx_first_r && rx_byte_i == tarf_pkg::TRANSPORT_START_BYTE;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_first_r     <= 1'b0;
			rx_out_valid_o <= 1'b0;
			rx_out_data_o  <= 8'h00;
		end else begin
			rx_out_valid_o <= rx_byte_valid_i && rx_enable_o && !rx_drop;
			if (rx_byte_valid_i) begin
				rx_out_data_o <= rx_byte_i;
			end
			if (rx_frame_start_i) begin
				rx_first_r <= 1'b1;
			end else if (rx_byte_valid_i) begin
				rx_first_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_tx_off_bad: assert property (!pause_ok |=> !tx_enable_o) // [R3]
		else $error("transmit enabled with unsupported pause code");
	a_raw_par_rate: assert property (raw_rx_parity_o |-> $past(rx_rate) == 2'h0) // [R5]
		else $error("raw parity outside 106k");
	a_rate_write: assert property (wr_rate && s_axi_wstrb[0] |=> // [R1]
		bit_rate_r == ($past(s_axi_wdata[7:0]) & tarf_pkg::BIT_RATE_SELECT_MASK))
		else $error("rate write not stored");
	a_parity_write: assert property (wr_frame && s_axi_wstrb[0] && s_axi_wdata[7] |=> // [R4]
		##1 !tx_parity_gen_o)
		else $error("parity still generated");
	a_hdr_start: assert property ($rose(hdr_valid_o) |-> hdr_data_o == 8'hf0) // [R7]
		else $error("header does not open with start byte");
	a_hdr_len: assert property (hdr_r == HDR_START && hdr_ready_i |=> // [R7]
		hdr_data_o == $past(len_r) && hdr_valid_o)
		else $error("length byte missing");
	a_rx_drop: assert property (rx_byte_valid_i && rx_drop |=> !rx_out_valid_o) // [R7]
		else $error("start byte passed through");
	a_pause_base: assert property (tx_rate == 2'h0 && pause_code == 4'h0 |=> // [R11]
		pause_width_o == 6'h23)
		else $error("pause base wrong");
	a_pause_fast: assert property (tx_rate == 2'h3 && pause_code == 4'hd |=> // [R11]
		pause_width_o == 6'h02)
		else $error("pause at /16 wrong");
	a_reserved_zero: assert property (rd_take && rd_idx == tarf_pkg::BIT_RATE_SELECT_IDX |=> // [R12]
		s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3:2] == 2'h0)
		else $error("reserved bits read nonzero");
	a_wr_resp: assert property (wr_take |=> s_axi_bvalid)
		else $error("write answer missing");

	c_hdr_sent:  cover property (hdr_r == HDR_LEN && hdr_ready_i);
	c_rx_drop:   cover property (rx_byte_valid_i && rx_drop);
	c_bad_pause: cover property (!pause_ok && !tx_enable_o);
	c_fast_rate: cover property (tx_bit_tick_o && tx_rate == 2'h3);

endmodule

/* tarf_rf_partner.sv */
// far-side model: carrier ticks and a header byte sink
// assumes the block's clock; stall_i slows the sink to one byte in four
`timescale 1ns/1ps
module tarf_rf_partner (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// control
	input  wire logic       stall_i,
	// carrier
	output logic            carrier_tick_o,
	// header sink
	input  wire logic       hdr_valid_i,
	input  wire logic [7:0] hdr_data_i,
	output logic            hdr_ready_o,
	output logic [7:0]      byte0_o,
	output logic [7:0]      byte1_o,
	output logic [1:0]      count_o
);
	logic [1:0] phase_r;

	////////////////////////////////////////
	// tick every second cycle keeps bit periods short
	assign carrier_tick_o = phase_r[0];
	assign hdr_ready_o    = !stall_i | (phase_r == 2'h3);
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase_r <= 2'h0;
			count_o <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
			if (hdr_valid_i && hdr_ready_o) begin
				count_o <= count_o + 2'h1;
				if (count_o == 2'h0) byte0_o <= hdr_data_i;
				else byte1_o <= hdr_data_i;
			end
		end
	end
endmodule

/* typea_rate_framing_config_tb.sv */
// bench for the rate and framing block over axi4-lite
// assumes tarf_pkg, tarf_config_top and tarf_rf_partner compiled first
`timescale 1ns/1ps
module typea_rate_framing_config_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, r_d, rd;
	logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic        aw_r, w_r, b_v, ar_r, r_v, c_tick, tx_tick, rx_tick;
	logic        tx_en, rx_en, par_gen, raw_par, rx_chk, coll, hdr_v, hdr_r;
	logic [1:0]  b_s, r_s, resp, hcnt;
	logic [5:0]  pw;
	logic        tx_start = 1'b0, stall = 1'b1, rx_st = 1'b0, rx_bv = 1'b0, rx_ov;
	logic [7:0]  tx_len = 8'h0, hdr_d, b0, b1, rx_b = 8'h0, rx_o;
	logic [7:0]  q[$];
	logic [6:0]  e;
	int          fail_count = 0, n_checks = 0;

	always #12.5 clk = ~clk;
	always @(posedge clk) if (rx_ov) q.push_back(rx_o);

	tarf_config_top u_dut (.clk_i(clk), .reset_i(rst),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
		.carrier_tick_i(c_tick), .tx_bit_tick_o(tx_tick), .rx_bit_tick_o(rx_tick),
		.tx_enable_o(tx_en), .rx_enable_o(rx_en), .tx_parity_gen_o(par_gen),
		.raw_rx_parity_o(raw_par), .rx_check_o(rx_chk), .collision_frame_o(coll),
		.pause_width_o(pw), .tx_start_i(tx_start), .tx_len_i(tx_len),
		.hdr_valid_o(hdr_v), .hdr_data_o(hdr_d), .hdr_ready_i(hdr_r),
		.rx_frame_start_i(rx_st), .rx_byte_valid_i(rx_bv), .rx_byte_i(rx_b),
		.rx_out_valid_o(rx_ov), .rx_out_data_o(rx_o));

	tarf_rf_partner u_far (.clk_i(clk), .reset_i(rst), .stall_i(stall),
		.carrier_tick_o(c_tick), .hdr_valid_i(hdr_v), .hdr_data_i(hdr_d),
		.hdr_ready_o(hdr_r), .byte0_o(b0), .byte1_o(b1), .count_o(hcnt));

	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic hang;
		fail_count++;
		$display("ERROR %0t wait ran out", $time);
		close_out();
	endtask

	// each channel held until its own ready
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (aw_v && aw_r) aw_v <= 1'b0;
			if (w_v && w_r) w_v <= 1'b0;
			if (b_v) break;
		end
		if (i == 50) hang();
		resp = b_s;
		b_r <= 1'b0;
	endtask

	task automatic rdr(input logic [31:0] a);
		int i;
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (ar_v && ar_r) ar_v <= 1'b0;
			if (r_v) break;
		end
		if (i == 50) hang();
		rd = r_d;
		resp = r_s;
		r_r <= 1'b0;
	endtask

	// derived outputs follow the register by one cycle
	task automatic upd;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// cycles between the second and third tick seen
	task automatic meas(input logic sel, input int per);
		int i, n, t0;
		n = 0;
		t0 = 0;
		for (i = 0; i < 1200; i++) begin
			@(posedge clk);
			if (sel ? rx_tick : tx_tick) begin
				n++;
				if (n == 2) t0 = i;
				if (n == 3) break;
			end
		end
		if (i == 1200) hang();
		chk(i - t0, per);
	endtask

	task automatic pulse_start(input logic [7:0] len);
		@(posedge clk);
		tx_start <= 1'b1;
		tx_len <= len;
		@(posedge clk);
		tx_start <= 1'b0;
		tx_len <= ~len;
	endtask

	// frame start, then f0 and 12 back to back
	task automatic rx_frame;
		q = {};
		@(posedge clk);
		rx_st <= 1'b1;
		@(posedge clk);
		rx_st <= 1'b0;
		rx_bv <= 1'b1;
		rx_b <= 8'hf0;
		@(posedge clk);
		rx_b <= 8'h12;
		@(posedge clk);
		rx_bv <= 1'b0;
		rx_b <= 8'hed;
		upd();
	endtask

	// {valid, width}: base plus signed code within the rate's limit
	function automatic logic [6:0] pexp(input int r, input int c);
		int lim[4] = '{8, 6, 4, 3};
		int base[4] = '{35, 18, 9, 5};
		int sc;
		sc = (c > 7) ? c - 16 : c;
		pexp = {(sc >= -lim[r] && sc <= lim[r]), 6'(base[r] + sc)};
	endfunction

	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		upd();
		chk(pw, 6'h23);
		chk(par_gen, 1'b1);
		chk(rx_en, 1'b1);
		rdr(32'h10);
		chk(rd, 32'h0);
		// status: tx and rx enabled, width 35
		rdr(32'h18);
		chk(rd, 32'he3);
		$display("test reset done");
		for (int r = 0; r < 4; r++) begin
			for (int c = 0; c < 16; c++) begin
				wr(32'h10, 32'(r << 4));
				wr(32'h14, 32'(c << 1));
				upd();
				e = pexp(r, c);
				chk(tx_en, e[6]);
				if (e[6]) chk(pw, e[5:0]);
				rdr(32'h14);
				chk(rd, 32'(c << 1));
			end
		end
		$display("test pause done");
		wr(32'h14, 32'h0);
		for (int r = 0; r < 4; r++) begin
			wr(32'h10, 32'(r << 4 | (3 - r)));
			upd();
			meas(1'b0, 2 * (128 >> r));
			meas(1'b1, 2 * (128 >> (3 - r)));
		end
		$display("test rates done");
		// parity options set in reader setup only
		wr(32'h14, 32'h80);
		upd();
		chk(par_gen, 1'b0);
		wr(32'h10, 32'h0);
		wr(32'h14, 32'h41);
		upd();
		chk({raw_par, rx_chk, coll}, 3'h5);
		wr(32'h10, 32'h1);
		upd();
		chk({raw_par, rx_chk}, 2'h1);
		wr(32'h10, 32'hff);
		rdr(32'h10);
		chk(rd, 32'h33);
		wr(32'h40, 32'h5);
		chk(resp, 2'h2);
		rdr(32'h40);
		chk(rd, 32'h0);
		chk(resp, 2'h2);
		$display("test options done");
		wr(32'h10, 32'h0);
		wr(32'h14, 32'h0);
		upd();
		pulse_start(8'h05);
		upd();
		chk(hdr_v, 1'b0);
		rx_frame();
		chk(q.size(), 32'h2);
		chk(q[0], 8'hf0);
		chk(q[1], 8'h12);
		// transport bit set only outside rate detection
		wr(32'h14, 32'h20);
		upd();
		pulse_start(8'h05);
		for (int i = 0; i < 100 && hcnt != 2'h2; i++) @(posedge clk);
		if (hcnt != 2'h2) hang();
		chk({hcnt, b0, b1}, {2'h2, 8'hf0, 8'h05});
		rx_frame();
		chk(q.size(), 32'h1);
		chk(q[0], 8'h12);
		$display("test transport done");
		close_out();
	end
endmodule
